//--- hw/pllc_pkg.sv
package pllc_pkg;

   // Clock and time conversion
   localparam int CLK_PERIOD_PS = 40000;

   // Least time: round up, never below one cycle
   function automatic int cyc_ceil(input int t_ps);
      int c;
      c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   // Longest time: round down, never below one cycle
   function automatic int cyc_floor(input int t_ps);
      int c;
      c = t_ps / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   // Shift register, latch and counter widths
   localparam int SR_W     = 24;
   localparam int REF_W    = 14;
   localparam int FB_W     = 13;
   localparam int ERR_W    = 8;
   localparam int LOCK_W   = 3;

   // Reference divider latch fields
   localparam int REF_DIV_LSB  = 2;
   localparam int ABP_LSB      = 16;
   localparam int TEST_LSB     = 18;
   localparam int LDP_BIT      = 20;

   // Feedback divider latch fields
   localparam int FB_DIV_LSB   = 8;
   localparam int GAIN_BIT     = 21;

   // Operating control latch fields
   localparam int CNT_RST_BIT  = 2;
   localparam int PD_A_BIT     = 3;
   localparam int MUX_LSB      = 4;
   localparam int POL_BIT      = 7;
   localparam int TRI_BIT      = 8;
   localparam int CPI_LSB      = 15;

   // Values after reset
   localparam logic [REF_W-1:0] REF_DIV_RST = 14'h0001;
   localparam logic [FB_W-1:0]  FB_DIV_RST  = 13'h0001;
   localparam logic [1:0]       ABP_RST     = 2'h0;
   localparam logic [2:0]       MUX_RST     = 3'h0;
   localparam logic [5:0]       CPI_RST     = 6'h00;
   localparam logic             POL_RST     = 1'b1;

   // Lock detection figures
   localparam int LOCK_ERR_PS   = 15000;
   localparam int UNLOCK_ERR_PS = 25000;
   localparam logic [ERR_W-1:0] LOCK_ERR_CYC   = ERR_W'(cyc_floor(LOCK_ERR_PS));
   localparam logic [ERR_W-1:0] UNLOCK_ERR_CYC = ERR_W'(cyc_floor(UNLOCK_ERR_PS));
   localparam logic [LOCK_W-1:0] LOCK_CNT_LO   = 3'h3;
   localparam logic [LOCK_W-1:0] LOCK_CNT_HI   = 3'h5;

   // Antibacklash widths
   localparam int ABP_2P9_PS = 2900;
   localparam int ABP_1P3_PS = 1300;
   localparam int ABP_6P0_PS = 6000;
   localparam logic [3:0] ABP_2P9_CYC = 4'(cyc_ceil(ABP_2P9_PS));
   localparam logic [3:0] ABP_1P3_CYC = 4'(cyc_ceil(ABP_1P3_PS));
   localparam logic [3:0] ABP_6P0_CYC = 4'(cyc_ceil(ABP_6P0_PS));

   // Latch select codes
   typedef enum logic [1:0] {
      SEL_REF  = 2'h0,
      SEL_FB   = 2'h1,
      SEL_CTRL = 2'h2,
      SEL_INIT = 2'h3
   } pllc_sel_t;

   // Observe pin sources
   typedef enum logic [2:0] {
      MUX_TRI    = 3'h0,
      MUX_DLOCK  = 3'h1,
      MUX_FBDIV  = 3'h2,
      MUX_HIGH   = 3'h3,
      MUX_REFDIV = 3'h4,
      MUX_ALOCK  = 3'h5,
      MUX_SDO    = 3'h6,
      MUX_LOW    = 3'h7
   } pllc_mux_t;

endpackage

//--- hw/pllc_sync.sv
`timescale 1ns/1ns
module pllc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   // Pins and filtered levels
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } pllc_sync_st_t;

   pllc_sync_st_t st_r;
   pllc_sync_st_t st_nxt;

   // Three stages; a bit moves once stages two and three agree
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_o = st_r.q;

endmodule

//--- hw/pllc_div.sv
`timescale 1ns/1ns
module pllc_div #(
   parameter int W = 14
) (
   // Clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   // Control
   input  wire logic         clr_i,
   input  wire logic         tick_i,
   input  wire logic [W-1:0] ratio_i,
   // Divided pulse
   output logic              pulse_o
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         pulse;
   } pllc_div_st_t;

   pllc_div_st_t st_r;
   pllc_div_st_t st_nxt;

   // Binary count of input edges; ratio zero acts as one
   always_comb begin
      st_nxt       = st_r;
      st_nxt.pulse = 1'b0;
      if (clr_i) begin
         st_nxt.cnt = '0;
      end else if (tick_i) begin
         if ((st_r.cnt + W'(1)) >= ratio_i) begin
            st_nxt.cnt   = '0;
            st_nxt.pulse = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pulse_o = st_r.pulse;

endmodule

//--- hw/pllc_top.sv
`timescale 1ns/1ns
module pllc_top (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic sys_rst_i,
   // Serial link pins
   input  wire logic serial_clk_i,
   input  wire logic serial_data_i,
   input  wire logic latch_load_strobe_i,
   input  wire logic chip_enable_i,
   // Frequency inputs
   input  wire logic ref_in_i,
   input  wire logic rf_in_i,
   // Charge pump
   output logic       pump_up_o,
   output logic       pump_dn_o,
   output logic       pump_oe_o,
   output logic       pump_gain_select_o,
   output logic [5:0] pump_current_code_o,
   // Observe pin
   output logic       observe_pin_o,
   output logic       observe_pin_oe_o,
   // Lock and power state
   output logic       lock_o,
   output logic       power_down_o,
   // Reference input switches
   output logic       ref_series_switch_a_o,
   output logic       ref_series_switch_b_o,
   output logic       ref_shunt_switch_o
);
   import pllc_pkg::*;

   typedef struct packed {
      logic [SR_W-1:0]   sr;
      logic              sclk_q;
      logic              le_q;
      logic              ref_q;
      logic              rf_q;
      logic [REF_W-1:0]  ref_div;
      logic [1:0]        abp;
      logic              lock_count_precision;
      logic [FB_W-1:0]   fb_div;
      logic              gain;
      logic [2:0]        mux;
      logic              cnt_rst;
      logic              pd_a;
      logic              pol;
      logic              tri_bit;
      logic [5:0]        cpi;
      logic              init_clr;
      logic              up;
      logic              dn;
      logic [3:0]        abp_cnt;
      logic [ERR_W-1:0]  err_cnt;
      logic [LOCK_W-1:0] good_cnt;
      logic              lock;
      logic              pump_up;
      logic              pump_dn;
      logic              pump_oe;
      logic              obs;
      logic              obs_oe;
      logic              pd;
      logic              sw_a;
      logic              sw_b;
      logic              shunt;
   } pllc_st_t;

   pllc_st_t st_r;
   pllc_st_t st_nxt;

   logic [5:0] pin_lvl;
   logic       sclk_s;
   logic       sdata_s;
   logic       le_s;
   logic       ce_s;
   logic       ref_s;
   logic       rf_s;
   logic       ref_pls;
   logic       fb_pls;
   logic       div_clr;

   // Rising edge of a filtered level
   function automatic logic rise(input logic now, input logic prev);
      return now & ~prev;
   endfunction

   // Antibacklash width in cycles per select code
   function automatic logic [3:0] abp_width(input logic [1:0] code);
      logic [3:0] w;
      w = ABP_2P9_CYC;
      unique case (code)
         2'h0: w = ABP_2P9_CYC;
         2'h1: w = ABP_1P3_CYC;
         2'h2: w = ABP_6P0_CYC;
         2'h3: w = ABP_2P9_CYC;
      endcase
      return w;
   endfunction

   // Lock count needed per precision bit
   function automatic logic [LOCK_W-1:0] lock_need(input logic prec);
      return prec ? LOCK_CNT_HI : LOCK_CNT_LO;
   endfunction

   // All asynchronous pins through the filter
   pllc_sync #(
      .W (6)
   ) u_sync (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     ({serial_clk_i, serial_data_i, latch_load_strobe_i,
                   chip_enable_i, ref_in_i, rf_in_i}),
      .level_o   (pin_lvl)
   );

   assign {sclk_s, sdata_s, le_s, ce_s, ref_s, rf_s} = pin_lvl;

   // Dividers held while powered down or under counter reset
   assign div_clr = st_r.pd | st_r.cnt_rst | st_r.init_clr;

   // Reference divider to the detector
   pllc_div #(
      .W (REF_W)
   ) u_ref_div (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .clr_i     (div_clr),
      .tick_i    (rise(ref_s, st_r.ref_q)),
      .ratio_i   (st_r.ref_div),
      .pulse_o   (ref_pls)
   );

   // Feedback divider to the detector
   pllc_div #(
      .W (FB_W)
   ) u_fb_div (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .clr_i     (div_clr),
      .tick_i    (rise(rf_s, st_r.rf_q)),
      .ratio_i   (st_r.fb_div),
      .pulse_o   (fb_pls)
   );

   // Next state of the whole block
   always_comb begin
      logic             pd_now;
      logic             both;
      logic             done;
      logic [ERR_W-1:0] err;
      logic             good;
      logic             bad;
      logic [3:0]       abp_next;
      logic             loaded;
      pd_now   = 1'b0;
      both     = 1'b0;
      done     = 1'b0;
      err      = '0;
      good     = 1'b0;
      bad      = 1'b0;
      abp_next = 4'h0;
      loaded   = 1'b0;
      st_nxt   = st_r;

      // Edge history
      st_nxt.sclk_q   = sclk_s;
      st_nxt.le_q     = le_s;
      st_nxt.ref_q    = ref_s;
      st_nxt.rf_q     = rf_s;
      st_nxt.init_clr = 1'b0;

      // Serial shift, MSB first, newest bit at position zero
      if (rise(sclk_s, st_r.sclk_q)) begin
         st_nxt.sr = {st_r.sr[SR_W-2:0], sdata_s};
      end

      // Latch transfer on strobe rise; strobe held low while shifting
      if (rise(le_s, st_r.le_q)) begin
         loaded = 1'b1;
         unique case (pllc_sel_t'(st_r.sr[1:0]))
            SEL_REF: begin
               st_nxt.ref_div = st_r.sr[REF_DIV_LSB +: REF_W];
               st_nxt.abp     = st_r.sr[ABP_LSB +: 2];
               st_nxt.lock_count_precision     = st_r.sr[LDP_BIT];
            end
            SEL_FB: begin
               st_nxt.fb_div = st_r.sr[FB_DIV_LSB +: FB_W];
               st_nxt.gain   = st_r.sr[GAIN_BIT];
            end
            SEL_CTRL, SEL_INIT: begin
               st_nxt.cnt_rst = st_r.sr[CNT_RST_BIT];
               st_nxt.pd_a    = st_r.sr[PD_A_BIT];
               st_nxt.mux     = st_r.sr[MUX_LSB +: 3];
               st_nxt.pol     = st_r.sr[POL_BIT];
               st_nxt.tri_bit = st_r.sr[TRI_BIT];
               st_nxt.cpi     = st_r.sr[CPI_LSB +: 6];
               st_nxt.init_clr = (st_r.sr[1:0] == SEL_INIT);
            end
         endcase
      end
      // Test and reserved bits are never stored

      // Power state from chip enable and software bit
      pd_now    = ~ce_s | st_r.pd_a;
      st_nxt.pd = pd_now;
      st_nxt.sw_a  = ~pd_now;
      st_nxt.sw_b  = ~pd_now;
      st_nxt.shunt = pd_now;

      // Error time: cycles with only one flag up
      if (st_r.up ^ st_r.dn) begin
         if (st_r.err_cnt != {ERR_W{1'b1}}) begin
            st_nxt.err_cnt = st_r.err_cnt + ERR_W'(1);
         end
      end

      // Both up: hold for the antibacklash width, then clear
      both = st_r.up & st_r.dn;
      if (both) begin
         abp_next = st_r.abp_cnt + 4'h1;
         if (abp_next >= abp_width(st_r.abp)) begin
            done           = 1'b1;
            st_nxt.up      = 1'b0;
            st_nxt.dn      = 1'b0;
            st_nxt.abp_cnt = 4'h0;
            st_nxt.err_cnt = '0;
         end else begin
            st_nxt.abp_cnt = abp_next;
         end
      end

      // Detector edges set flags after the clear, so a new edge wins
      if (ref_pls) begin
         st_nxt.up = 1'b1;
      end
      if (fb_pls) begin
         st_nxt.dn = 1'b1;
      end

      // Per-cycle lock evaluation at detector reset
      if (done) begin
         err  = st_r.err_cnt;
         good = (err < LOCK_ERR_CYC);
         bad  = (err >= UNLOCK_ERR_CYC);
         if (good) begin
            if (st_r.good_cnt < lock_need(st_r.lock_count_precision)) begin
               st_nxt.good_cnt = st_r.good_cnt + LOCK_W'(1);
            end
            if ((st_r.good_cnt + LOCK_W'(1)) >= lock_need(st_r.lock_count_precision)) begin
               st_nxt.lock = 1'b1;
            end
         end else begin
            st_nxt.good_cnt = '0;
         end
         if (bad) begin
            st_nxt.lock = 1'b0;
         end
      end

      // Powered down or held: detector idle, lock lost
      if (div_clr) begin
         st_nxt.up       = 1'b0;
         st_nxt.dn       = 1'b0;
         st_nxt.abp_cnt  = 4'h0;
         st_nxt.err_cnt  = '0;
         st_nxt.good_cnt = '0;
         st_nxt.lock     = 1'b0;
      end

      // Pump outputs with polarity swap and three-state
      st_nxt.pump_up = st_r.pol ? st_r.up : st_r.dn;
      st_nxt.pump_dn = st_r.pol ? st_r.dn : st_r.up;
      st_nxt.pump_oe = ~pd_now & ~st_r.tri_bit;

      // Observe pin source
      st_nxt.obs    = 1'b0;
      st_nxt.obs_oe = 1'b1;
      unique case (pllc_mux_t'(st_r.mux))
         MUX_TRI: begin
            st_nxt.obs_oe = 1'b0;
         end
         MUX_DLOCK: begin
            st_nxt.obs = st_r.lock;
         end
         MUX_FBDIV: begin
            st_nxt.obs = fb_pls;
         end
         MUX_HIGH: begin
            st_nxt.obs = 1'b1;
         end
         MUX_REFDIV: begin
            st_nxt.obs = ref_pls;
         end
         MUX_ALOCK: begin
            st_nxt.obs_oe = st_r.up | st_r.dn;
         end
         MUX_SDO: begin
            st_nxt.obs = st_r.sr[SR_W-1];
         end
         MUX_LOW: begin
            st_nxt.obs = 1'b0;
         end
      endcase
      if (loaded) begin
         st_nxt.err_cnt = st_nxt.err_cnt;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r         <= '0;
         st_r.ref_div <= REF_DIV_RST;
         st_r.fb_div  <= FB_DIV_RST;
         st_r.abp     <= ABP_RST;
         st_r.mux     <= MUX_RST;
         st_r.cpi     <= CPI_RST;
         st_r.pol     <= POL_RST;
         st_r.pd      <= 1'b1;
         st_r.shunt   <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign pump_up_o             = st_r.pump_up;
   assign pump_dn_o             = st_r.pump_dn;
   assign pump_oe_o             = st_r.pump_oe;
   assign pump_gain_select_o    = st_r.gain;
   assign pump_current_code_o   = st_r.cpi;
   assign observe_pin_o         = st_r.obs;
   assign observe_pin_oe_o      = st_r.obs_oe;
   assign lock_o                = st_r.lock;
   assign power_down_o          = st_r.pd;
   assign ref_series_switch_a_o = st_r.sw_a;
   assign ref_series_switch_b_o = st_r.sw_b;
   assign ref_shunt_switch_o    = st_r.shunt;

endmodule

//--- verification/pllc_host_model.sv
`timescale 1ns/1ns
module pllc_host_model (
   // Clock
   input  wire logic sys_clk_i,
   // Serial link pins
   output logic      serial_clk_o,
   output logic      serial_data_o,
   output logic      latch_load_strobe_o
);
   // Link idles with clock and strobe low
   initial begin
      serial_clk_o        = 1'b0;
      serial_data_o       = 1'b0;
      latch_load_strobe_o = 1'b0;
   end

   // Each level held four cycles, above the filter minimum
   task automatic hold();
      repeat (4) @(negedge sys_clk_i);
   endtask

   // One word, top bit first, strobe raised after the last bit
   task automatic send(input logic [23:0] word);
      for (int i = 23; i >= 0; i--) begin
         serial_data_o = word[i];
         hold();
         serial_clk_o = 1'b1;
         hold();
         serial_clk_o = 1'b0;
      end
      serial_data_o = ~word[0];
      hold();
      latch_load_strobe_o = 1'b1;
      hold();
      latch_load_strobe_o = 1'b0;
      hold();
   endtask
endmodule

//--- verification/pllc_monitor.sv
`timescale 1ns/1ns
module pllc_monitor (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Watched pins
   input wire logic chip_enable_i,
   input wire logic pump_up_o,
   input wire logic pump_dn_o,
   input wire logic pump_oe_o,
   input wire logic lock_o,
   input wire logic power_down_o,
   input wire logic ref_series_switch_a_o,
   input wire logic ref_series_switch_b_o,
   input wire logic ref_shunt_switch_o
);
   // All checks on the system clock, quiet in reset
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   chk_pd_switches: assert property (power_down_o [*2] |->
      !ref_series_switch_a_o && !ref_series_switch_b_o && ref_shunt_switch_o)
      else $error("switches wrong while powered down");
   chk_run_switches: assert property ((!power_down_o) [*2] |->
      ref_series_switch_a_o && ref_series_switch_b_o && !ref_shunt_switch_o)
      else $error("switches wrong while running");
   chk_ce_down: assert property ((!chip_enable_i) [*8] |-> power_down_o)
      else $error("chip enable low did not power down");
   chk_ce_pump_off: assert property ((!chip_enable_i) [*8] |-> !pump_oe_o)
      else $error("pump driven with chip enable low");
   chk_pd_no_lock: assert property (power_down_o [*3] |-> !lock_o)
      else $error("lock shown while powered down");
   chk_abp_width: assert property (pump_up_o && pump_dn_o |=> !(pump_up_o && pump_dn_o))
      else $error("overlap pulse longer than one cycle");
   chk_up_holds: assert property (chip_enable_i [*8] ##0 (pump_up_o && !pump_dn_o)
      |=> pump_up_o)
      else $error("up dropped before down arrived");
   chk_dn_holds: assert property (chip_enable_i [*8] ##0 (pump_dn_o && !pump_up_o)
      |=> pump_dn_o)
      else $error("down dropped before up arrived");
   chk_lock_clears: assert property ((pump_up_o ^ pump_dn_o) ##1
      (pump_up_o && pump_dn_o) |-> ##[0:6] !lock_o)
      else $error("lock kept after large phase error");
   chk_lock_quiet: assert property ($rose(lock_o) |-> !(pump_up_o ^ pump_dn_o))
      else $error("lock rose during phase error");
endmodule

bind pllc_top pllc_monitor i_pllc_monitor (.sys_clk_i, .sys_rst_i, .chip_enable_i,
   .pump_up_o, .pump_dn_o, .pump_oe_o, .lock_o, .power_down_o, .ref_series_switch_a_o,
   .ref_series_switch_b_o, .ref_shunt_switch_o);

//--- verification/pllc_top_tb_top.sv
`timescale 1ns/1ns
module pllc_top_tb_top;
   import pllc_pkg::*;
   // Pins of the block
   logic       sys_clk_i     = 1'b0;
   logic       sys_rst_i     = 1'b1;
   logic       chip_enable_i = 1'b1;
   logic       ref_in_i      = 1'b0;
   logic       rf_in_i       = 1'b0;
   logic       serial_clk_i, serial_data_i, latch_load_strobe_i;
   logic       pump_up_o, pump_dn_o, pump_oe_o, pump_gain_select_o, lock_o, power_down_o;
   logic       observe_pin_o, observe_pin_oe_o;
   logic       ref_series_switch_a_o, ref_series_switch_b_o, ref_shunt_switch_o;
   logic [5:0] pump_current_code_o;
   int         err_total  = 0;
   int         compares   = 0;
   int         obs_pulses = 0;
   // Observe pin table: mux code, top bits, expected {pin, enable}
   localparam logic [2:0] MX_M [6] = '{3'h0, 3'h3, 3'h7, 3'h5, 3'h6, 3'h6};
   localparam logic [1:0] MX_R [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0};
   localparam logic [1:0] MX_E [6] = '{2'h0, 2'h3, 2'h1, 2'h0, 2'h3, 2'h1};

   always #20 sys_clk_i = ~sys_clk_i;

   // Count observe pin high cycles
   always @(negedge sys_clk_i) if (observe_pin_o === 1'b1) obs_pulses++;

   pllc_host_model i_pllc_host_model (.sys_clk_i, .serial_clk_o(serial_clk_i),
      .serial_data_o(serial_data_i), .latch_load_strobe_o(latch_load_strobe_i));

   pllc_top i_pllc_top (.sys_clk_i, .sys_rst_i, .serial_clk_i, .serial_data_i,
      .latch_load_strobe_i, .chip_enable_i, .ref_in_i, .rf_in_i, .pump_up_o, .pump_dn_o,
      .pump_oe_o, .pump_gain_select_o, .pump_current_code_o, .observe_pin_o,
      .observe_pin_oe_o, .lock_o, .power_down_o, .ref_series_switch_a_o,
      .ref_series_switch_b_o, .ref_shunt_switch_o);

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic tdone(input string name);
      $display("test %s finished", name);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask

   // Rising edges on the frequency inputs, eight cycles per level
   task automatic edges(input logic r, input logic f, input int n);
      repeat (n) begin
         ref_in_i = r;
         rf_in_i  = f;
         wait_cyc(8);
         ref_in_i = 1'b0;
         rf_in_i  = 1'b0;
         wait_cyc(8);
      end
   endtask

   task automatic wr(input logic [23:0] w);
      i_pllc_host_model.send(w);
      wait_cyc(6);
   endtask

   // Control word: top bits, current 2D, pump off, polarity 1, mux, power-down
   function automatic logic [23:0] ctrl_w(input logic [2:0] m, input logic [1:0] rsv,
                                          input logic pump_off, input logic pd);
      return {rsv, 1'b0, 6'h2D, 6'h00, pump_off, 1'b1, m, pd, 1'b0, 2'h2};
   endfunction

   // One leading edge alone, then the lagging one
   task automatic unlock(input logic ref_first);
      edges(ref_first, !ref_first, 1);
      check("lead flag", {pump_up_o, pump_dn_o}, ref_first ? 2'h2 : 2'h1);
      check("held lock", lock_o, 1'b1);
      edges(!ref_first, ref_first, 1);
      check("lock lost", lock_o, 1'b0);
   endtask

   // Hang guard
   initial begin
      wait_cyc(100000);
      err_total++;
      end_sim();
   end

   initial begin
      wait_cyc(2);
      check("in reset", {power_down_o, ref_shunt_switch_o, ref_series_switch_a_o,
         ref_series_switch_b_o, lock_o, pump_oe_o}, 6'h30);
      wait_cyc(6);
      sys_rst_i = 1'b0;
      wait_cyc(10);
      check("running", {power_down_o, ref_shunt_switch_o, ref_series_switch_a_o,
         ref_series_switch_b_o}, 4'h3);
      check("obs idle", observe_pin_oe_o, 1'b0);
      tdone("reset");
      wr(24'h2001FD);
      check("gain", pump_gain_select_o, 1'b1);
      wr(24'hE00004);
      for (int i = 0; i < 6; i++) begin
         wr(ctrl_w(MX_M[i], MX_R[i], 1'b0, 1'b0));
         check("observe", {observe_pin_o & (MX_M[i] != 3'h0), observe_pin_oe_o}, MX_E[i]);
         check("current", pump_current_code_o, 6'h2D);
         check("pump on", pump_oe_o, 1'b1);
      end
      tdone("latches");
      wr(ctrl_w(3'h1, 2'h0, 1'b1, 1'b0));
      check("pump off", pump_oe_o, 1'b0);
      wr(ctrl_w(3'h1, 2'h0, 1'b0, 1'b1));
      check("soft pd", {power_down_o, ref_shunt_switch_o}, 2'h3);
      wr(ctrl_w(3'h1, 2'h0, 1'b0, 1'b0) ^ 24'h1F8001);
      check("init latch", {pump_current_code_o, power_down_o}, 7'h24);
      tdone("control");
      edges(1'b1, 1'b1, 2);
      check("lock early p0", lock_o, 1'b0);
      edges(1'b1, 1'b1, 1);
      check("lock p0", {lock_o, observe_pin_o}, 2'h3);
      unlock(1'b1);
      wr(24'h100004);
      edges(1'b1, 1'b1, 4);
      check("lock early p1", lock_o, 1'b0);
      edges(1'b1, 1'b1, 1);
      check("lock p1", lock_o, 1'b1);
      unlock(1'b0);
      tdone("lock");
      chip_enable_i = 1'b0;
      wait_cyc(10);
      check("ce low", {power_down_o, ref_shunt_switch_o, ref_series_switch_a_o,
         ref_series_switch_b_o, pump_oe_o}, 5'h18);
      chip_enable_i = 1'b1;
      wait_cyc(10);
      check("ce high", power_down_o, 1'b0);
      tdone("power");
      // Polarity swapped, open-drain lock source on the observe pin
      wr(ctrl_w(3'h5, 2'h0, 1'b0, 1'b0) ^ 24'h000080);
      edges(1'b1, 1'b0, 1);
      check("swap lead", {pump_up_o, pump_dn_o, observe_pin_o, observe_pin_oe_o}, 4'h5);
      edges(1'b0, 1'b1, 1);
      check("swap done", {pump_up_o, pump_dn_o, observe_pin_oe_o}, 3'h0);
      tdone("polarity");
      wr(24'h200301);
      wr(24'h000014);
      for (int k = 0; k < 2; k++) begin
         wr(ctrl_w(k ? 3'h4 : 3'h2, 2'h0, 1'b0, 1'b0));
         obs_pulses = 0;
         edges(1'b1, 1'b1, 15);
         check("divider", obs_pulses, k ? 3 : 5);
      end
      tdone("dividers");
      end_sim();
   end
endmodule
